// ---- rtl/bst_pkg.sv ----
// Constants, types and codes shared by the boundary-scan test access port.
//
// Summary of operation
// - Mode select at scan-clock rise decides next state.
// - Reset gives Test-Logic-Reset, IDCODE, normal system operation.
// - Select-DR-Scan: low to Capture-DR, high Select-IR.
// - Capture-DR loads selected register if allowed; low Shift-DR.
// - Shift-DR moves selected register one stage per rise.
// - Exit1-DR: high to Update-DR, low to Pause-DR.
// - Pause-DR holds registers; low stays, high Exit2-DR.
// - Exit2-DR: high to Update-DR, low back Shift-DR.
// - Update-DR falling edge copies shift path into latches.
// - Update states: low to Run-Test-Idle, high Select-DR-Scan.
// - Select-IR-Scan: low Capture-IR, high Test-Logic-Reset.
// - Capture-IR loads fixed value; high Exit1-IR, low Shift-IR.
// - Shift-IR shifts instruction stage per rise; high Exit1-IR.
// - Exit1-IR: low Pause-IR, high Update-IR.
// - Pause-IR halts shifting; low stays, high Exit2-IR.
// - Exit2-IR: high Update-IR, low back to Shift-IR.
// - Three-bit instruction latched on Update-IR falling edge.
// - Codes 010 and 000 boundary; 111 bypass.
// - Codes 011 and 100 bypass; 001 identification.
// - Sample/preload captures pins without disturbing operation.
// - Extest drives output pins from boundary latches.
// - Bypass-type instructions use one-stage bypass register.
// - Identification register selected, loads in Capture-DR.
// - Identification: one, maker eleven, part sixteen, version four.
package bst_pkg;

   // ----------------------------------------------------------------
   // Widths and field positions
   // ----------------------------------------------------------------
   localparam int IR_LEN = 3; // Instruction register length.
   localparam int ID_LEN = 32; // Identification register length.
   localparam int ID_MFR_LSB = 1; // Maker code sits above the marker bit.
   localparam int ID_PART_LSB = 12; // Part code field position.
   localparam int ID_VER_LSB = 28; // Version field position.

   // ----------------------------------------------------------------
   // Instruction codes and the fixed capture value
   // ----------------------------------------------------------------
   localparam logic [2:0] INSTR_EXTEST = 3'h0;
   localparam logic [2:0] INSTR_IDCODE = 3'h1;
   localparam logic [2:0] INSTR_SAMPLE = 3'h2;
   localparam logic [2:0] INSTR_CLAMP = 3'h3;
   localparam logic [2:0] INSTR_HIGHZ = 3'h4;
   localparam logic [2:0] INSTR_BYPASS = 3'h7;
   localparam logic [2:0] IR_CAPTURE = 3'h1; // Low bits 01 prove chain integrity.
   localparam logic [2:0] INSTR_RESET = INSTR_IDCODE; // Instruction after reset.
   localparam logic BYPASS_CAPTURE = 1'h0; // Bypass stage loads zero.

   // ----------------------------------------------------------------
   // Controller states, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [15:0] {
      ST_TLR = 16'h0001, ST_RTI = 16'h0002, ST_SEL_DR = 16'h0004, ST_CAP_DR = 16'h0008,
      ST_SHIFT_DR = 16'h0010, ST_EXIT1_DR = 16'h0020, ST_PAUSE_DR = 16'h0040,
      ST_EXIT2_DR = 16'h0080, ST_UPD_DR = 16'h0100, ST_SEL_IR = 16'h0200,
      ST_CAP_IR = 16'h0400, ST_SHIFT_IR = 16'h0800, ST_EXIT1_IR = 16'h1000,
      ST_PAUSE_IR = 16'h2000, ST_EXIT2_IR = 16'h4000, ST_UPD_IR = 16'h8000
   } bst_state_t;

   localparam bst_state_t ST_RESET = ST_TLR; // State after reset.

endpackage : bst_pkg

// ---- rtl/bst_tap.sv ----
// Boundary-scan test access port: controller, instruction and test registers.
`timescale 1ns/1ps
`default_nettype none

module bst_tap
   import bst_pkg::*;
#(
   parameter int N_IN = 8, // Number of digital input pins with scan cells.
   parameter int N_OUT = 8, // Number of digital output pins with scan cells.
   parameter logic [3:0] ID_VERSION = 4'h1, // Arbitrary version value.
   parameter logic [15:0] ID_PART = 16'h0a5c, // Arbitrary part value.
   parameter logic [10:0] ID_MFR = 11'h05a // Arbitrary maker value.
)(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic scan_clock,
   input wire logic scan_mode_select,
   input wire logic scan_data_in,
   output logic scan_data_out,
   output logic scan_data_out_oe,
   input wire logic [N_IN-1:0] pin_in,
   input wire logic [N_OUT-1:0] core_out,
   input wire logic core_oe,
   output logic [N_OUT-1:0] pin_out,
   output logic pin_oe,
   output logic [2:0] cur_instr,
   output logic [15:0] tap_state
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   // The boundary register needs at least one cell of each kind.
   if (N_IN < 1 || N_OUT < 1) begin : g_bad_size
      $error("bst_tap: N_IN and N_OUT must be at least one");
   end

   // Boundary register: input cells low, output cells next, control cell on top.
   localparam int BSR_LEN = N_IN + N_OUT + 1;
   localparam int OUT_LSB = N_IN;
   localparam int CTL_BIT = N_IN + N_OUT;
   localparam logic [ID_LEN-1:0] ID_CODE = {ID_VERSION, ID_PART, ID_MFR, 1'b1};

   // The identification fields must tile the register exactly, marker bit included.
   if (ID_PART_LSB != ID_MFR_LSB + $bits(ID_MFR) || ID_VER_LSB != ID_PART_LSB + $bits(ID_PART) ||
       ID_VER_LSB + $bits(ID_VERSION) != ID_LEN) begin : g_bad_id
      $error("bst_tap: identification field layout does not fill the register");
   end

   // ----------------------------------------------------------------
   // State record
   // ----------------------------------------------------------------
   // Every flip-flop of the block lives in this one record.
   typedef struct packed {
      logic sclk_m; // Scan clock, first synchroniser stage.
      logic sclk_s; // Scan clock, second synchroniser stage.
      logic sclk_d; // Delayed copy used to find edges.
      logic tms_m; // Mode select, first stage.
      logic tms_s; // Mode select, second stage.
      logic tdi_m; // Serial data in, first stage.
      logic tdi_s; // Serial data in, second stage.
      logic [N_IN-1:0] pin_m; // Input pins, first stage.
      logic [N_IN-1:0] pin_s; // Input pins, second stage.
      bst_state_t state; // Controller state.
      logic [IR_LEN-1:0] ir_shift; // Instruction shift stage.
      logic [IR_LEN-1:0] instr; // Current instruction.
      logic byp; // Bypass stage.
      logic [ID_LEN-1:0] id_shift; // Identification shift path.
      logic [BSR_LEN-1:0] bsr_shift; // Boundary shift path.
      logic [BSR_LEN-1:0] bsr_latch; // Boundary parallel latches.
      logic tdo; // Serial data out.
      logic tdo_oe; // Serial data out enable.
      logic [N_OUT-1:0] pin_out; // Output pin values.
      logic pin_oe; // Output pin enable.
   } bst_regs_t;

   bst_regs_t s; // Registered state.
   bst_regs_t next_s; // Next state.
   logic rise; // Scan clock rose this cycle.
   logic fall; // Scan clock fell this cycle.

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------
   // True when the instruction puts the boundary register in the path.
   function automatic logic sel_boundary(input logic [2:0] code);
      sel_boundary = (code == INSTR_EXTEST) || (code == INSTR_SAMPLE);
   endfunction : sel_boundary

   // True when the identification register is in the path.
   function automatic logic sel_ident(input logic [2:0] code);
      sel_ident = (code == INSTR_IDCODE);
   endfunction : sel_ident

   // Next controller state for a given mode select level.
   function automatic bst_state_t tap_next(input bst_state_t st, input logic tms);
      tap_next = st;
      unique case (st)
         ST_TLR: tap_next = tms ? ST_TLR : ST_RTI;
         ST_RTI: tap_next = tms ? ST_SEL_DR : ST_RTI;
         ST_SEL_DR: tap_next = tms ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: tap_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_SHIFT_DR: tap_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_EXIT1_DR: tap_next = tms ? ST_UPD_DR : ST_PAUSE_DR;
         ST_PAUSE_DR: tap_next = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
         ST_EXIT2_DR: tap_next = tms ? ST_UPD_DR : ST_SHIFT_DR;
         ST_UPD_DR: tap_next = tms ? ST_SEL_DR : ST_RTI;
         ST_SEL_IR: tap_next = tms ? ST_TLR : ST_CAP_IR;
         ST_CAP_IR: tap_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_SHIFT_IR: tap_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_EXIT1_IR: tap_next = tms ? ST_UPD_IR : ST_PAUSE_IR;
         ST_PAUSE_IR: tap_next = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
         ST_EXIT2_IR: tap_next = tms ? ST_UPD_IR : ST_SHIFT_IR;
         ST_UPD_IR: tap_next = tms ? ST_SEL_DR : ST_RTI;
         // A corrupted code recovers through the reset state.
         default: tap_next = ST_TLR;
      endcase
   endfunction : tap_next

   // ----------------------------------------------------------------
   // Edge detection
   // ----------------------------------------------------------------
   // Edges are taken from the second and third stages only, so the
   // metastable first stage never feeds any decision.
   // Limitation: each scan clock phase must last one core cycle or more,
   // otherwise an edge slips between two samples and is lost.
   assign rise = s.sclk_s & ~s.sclk_d;
   assign fall = ~s.sclk_s & s.sclk_d;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   // Rising scan edges move the controller and the shift paths; falling
   // edges drive serial out and load the parallel latches.
   always_comb begin
      next_s = s;
      // Synchronisers for everything that comes from the pins.
      next_s.sclk_m = scan_clock;
      next_s.sclk_s = s.sclk_m;
      next_s.sclk_d = s.sclk_s;
      next_s.tms_m = scan_mode_select;
      next_s.tms_s = s.tms_m;
      next_s.tdi_m = scan_data_in;
      next_s.tdi_s = s.tdi_m;
      next_s.pin_m = pin_in;
      next_s.pin_s = s.pin_m;

      // Rising edge: mode select alone chooses the next state.
      if (rise) begin
         next_s.state = tap_next(s.state, s.tms_s);
         unique case (s.state)
            ST_CAP_DR: begin
               // Only the selected register loads; the others hold.
               if (sel_ident(s.instr)) begin
                  next_s.id_shift = ID_CODE;
               end else if (sel_boundary(s.instr)) begin
                  // Pins are sampled while the core keeps running.
                  next_s.bsr_shift[N_IN-1:0] = s.pin_s;
                  next_s.bsr_shift[CTL_BIT-1:OUT_LSB] = core_out;
                  next_s.bsr_shift[CTL_BIT] = core_oe;
               end else begin
                  next_s.byp = BYPASS_CAPTURE;
               end
            end
            ST_SHIFT_DR: begin
               // The selected register moves one stage toward serial out.
               if (sel_ident(s.instr)) begin
                  next_s.id_shift = {s.tdi_s, s.id_shift[ID_LEN-1:1]};
               end else if (sel_boundary(s.instr)) begin
                  next_s.bsr_shift = {s.tdi_s, s.bsr_shift[BSR_LEN-1:1]};
               end else begin
                  next_s.byp = s.tdi_s;
               end
            end
            ST_CAP_IR: begin
               next_s.ir_shift = IR_CAPTURE;
            end
            ST_SHIFT_IR: begin
               next_s.ir_shift = {s.tdi_s, s.ir_shift[IR_LEN-1:1]};
            end
            // Pause, exit and select states hold every register.
            default: begin
            end
         endcase
      end

      // Falling edge: serial out and the parallel latches.
      if (fall) begin
         next_s.tdo_oe = 1'b0;
         unique case (s.state)
            ST_SHIFT_DR: begin
               next_s.tdo_oe = 1'b1;
               if (sel_ident(s.instr)) begin
                  next_s.tdo = s.id_shift[0];
               end else if (sel_boundary(s.instr)) begin
                  next_s.tdo = s.bsr_shift[0];
               end else begin
                  next_s.tdo = s.byp;
               end
            end
            ST_SHIFT_IR: begin
               next_s.tdo_oe = 1'b1;
               next_s.tdo = s.ir_shift[0];
            end
            ST_UPD_DR: begin
               // Latches change only here, so shifting never disturbs pins.
               if (sel_boundary(s.instr)) begin
                  next_s.bsr_latch = s.bsr_shift;
               end
            end
            ST_UPD_IR: begin
               next_s.instr = s.ir_shift;
            end
            default: begin
            end
         endcase
      end

      // The reset state forces the identification instruction.
      if (s.state == ST_TLR) begin
         next_s.instr = INSTR_RESET;
      end

      // Pin drive follows the current instruction.
      unique case (s.instr)
         INSTR_EXTEST, INSTR_CLAMP: begin
            // Pins come from the boundary latches, not the core.
            next_s.pin_out = s.bsr_latch[CTL_BIT-1:OUT_LSB];
            next_s.pin_oe = s.bsr_latch[CTL_BIT];
         end
         INSTR_HIGHZ: begin
            // Only the enable drops; the value keeps tracking the core so leaving is clean.
            next_s.pin_out = core_out;
            next_s.pin_oe = 1'b0;
         end
         default: begin
            // Normal operation: the core owns its pins.
            next_s.pin_out = core_out;
            next_s.pin_oe = core_oe;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // A synchronous reset stands in for power-up.
   // The synchronisers clear too, so a scan clock left high across reset reads as a rise.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         s <= '0;
         s.state <= ST_RESET;
         s.instr <= INSTR_RESET;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // All outputs are flip-flop fields of the state record.
   assign scan_data_out = s.tdo;
   assign scan_data_out_oe = s.tdo_oe;
   assign pin_out = s.pin_out;
   assign pin_oe = s.pin_oe;
   assign cur_instr = s.instr;
   assign tap_state = s.state;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // Without a scan edge the controller never moves.
   state_hold_a: assert property (@(posedge core_clk) disable iff (srst)
      !rise |=> $stable(s.state))
      else $error("state moved without a scan clock rise");

   // The reset state always carries the identification instruction.
   reset_instr_a: assert property (@(posedge core_clk) disable iff (srst)
      s.state == ST_TLR |=> s.instr == INSTR_IDCODE)
      else $error("instruction not forced in reset state");

   // Reset state is held while mode select stays high.
   tlr_hold_a: assert property (@(posedge core_clk) disable iff (srst)
      (s.state == ST_TLR && rise && s.tms_s) |=> s.state == ST_TLR)
      else $error("left reset state with mode select high");

   // Select-DR-Scan with low select enters Capture-DR.
   sel_dr_a: assert property (@(posedge core_clk) disable iff (srst)
      (s.state == ST_SEL_DR && rise && !s.tms_s) |=> s.state == ST_CAP_DR)
      else $error("select-dr did not go to capture-dr");

   // Capture-IR loads the fixed pattern.
   cap_ir_a: assert property (@(posedge core_clk) disable iff (srst)
      (s.state == ST_CAP_IR && rise) |=> s.ir_shift == 3'h1)
      else $error("capture-ir pattern wrong");

   // Update-IR falling edge makes the shifted code current.
   upd_ir_a: assert property (@(posedge core_clk) disable iff (srst)
      (s.state == ST_UPD_IR && fall) |=> s.instr == $past(s.ir_shift))
      else $error("instruction not latched at update-ir");

   // Identification capture loads the full code.
   id_cap_a: assert property (@(posedge core_clk) disable iff (srst)
      (s.state == ST_CAP_DR && rise && s.instr == INSTR_IDCODE) |=> s.id_shift == ID_CODE)
      else $error("identification code not captured");

   // Bypass stage takes serial data in while shifting.
   bypass_shift_a: assert property (@(posedge core_clk) disable iff (srst)
      (s.state == ST_SHIFT_DR && rise && s.instr == INSTR_BYPASS) |=> s.byp == $past(s.tdi_s))
      else $error("bypass stage did not shift");

   // Pause-DR with low select holds state and boundary path.
   pause_dr_a: assert property (@(posedge core_clk) disable iff (srst)
      (s.state == ST_PAUSE_DR && rise && !s.tms_s) |=> (s.state == ST_PAUSE_DR) && $stable(s.bsr_shift))
      else $error("pause-dr did not hold");

   // High-impedance instruction floats the pins one cycle on.
   highz_float_a: assert property (@(posedge core_clk) disable iff (srst)
      (s.instr == INSTR_HIGHZ) [*2] |-> !s.pin_oe)
      else $error("pins driven under highz");

   // Extest drives pins from the boundary latches.
   extest_drive_a: assert property (@(posedge core_clk) disable iff (srst)
      s.instr == INSTR_EXTEST |=> s.pin_out == $past(s.bsr_latch[CTL_BIT-1:OUT_LSB]))
      else $error("extest pins differ from latches");

   // Latches change only on an Update-DR falling edge.
   latch_stable_a: assert property (@(posedge core_clk) disable iff (srst)
      !(s.state == ST_UPD_DR && fall) |=> $stable(s.bsr_latch))
      else $error("boundary latches changed outside update-dr");

   // Select-IR-Scan with high select falls back to the reset state.
   sel_ir_exit_a: assert property (@(posedge core_clk) disable iff (srst)
      (s.state == ST_SEL_IR && rise && s.tms_s) |=> s.state == ST_TLR)
      else $error("select-ir did not return to reset state");

   // Both select states leave the instruction path untouched.
   select_hold_a: assert property (@(posedge core_clk) disable iff (srst)
      (s.state == ST_SEL_DR || s.state == ST_SEL_IR) |=> $stable(s.ir_shift) && $stable(s.instr))
      else $error("instruction path changed in a select state");

   // Exit1-DR with high select ends the scan in Update-DR.
   exit1_dr_a: assert property (@(posedge core_clk) disable iff (srst)
      (s.state == ST_EXIT1_DR && rise && s.tms_s) |=> s.state == ST_UPD_DR)
      else $error("exit1-dr did not go to update-dr");

   // Exit2-IR with high select ends the scan in Update-IR.
   exit2_ir_a: assert property (@(posedge core_clk) disable iff (srst)
      (s.state == ST_EXIT2_IR && rise && s.tms_s) |=> s.state == ST_UPD_IR)
      else $error("exit2-ir did not go to update-ir");

   // Pause-IR with low select holds state and instruction path.
   pause_ir_a: assert property (@(posedge core_clk) disable iff (srst)
      (s.state == ST_PAUSE_IR && rise && !s.tms_s) |=> (s.state == ST_PAUSE_IR) && $stable(s.ir_shift))
      else $error("pause-ir did not hold");

   // Instruction scans drive the low shift stage out with the enable high.
   ir_out_a: assert property (@(posedge core_clk) disable iff (srst)
      (s.state == ST_SHIFT_IR && fall) |=> s.tdo_oe && s.tdo == $past(s.ir_shift[0]))
      else $error("shift-ir serial out wrong");

   // The identification path moves one stage toward serial out per rise.
   id_shift_a: assert property (@(posedge core_clk) disable iff (srst)
      (s.state == ST_SHIFT_DR && rise && s.instr == INSTR_IDCODE) |=>
         s.id_shift == {$past(s.tdi_s), $past(s.id_shift[ID_LEN-1:1])})
      else $error("identification path did not shift");

   // Update-DR falling edge copies the boundary path into the latches.
   update_latch_a: assert property (@(posedge core_clk) disable iff (srst)
      (s.state == ST_UPD_DR && fall && sel_boundary(s.instr)) |=> s.bsr_latch == $past(s.bsr_shift))
      else $error("boundary latches not loaded at update-dr");

   // Sample/preload leaves the pins to the core, one cycle behind it.
   core_pins_a: assert property (@(posedge core_clk) disable iff (srst)
      s.instr == INSTR_SAMPLE |=> s.pin_out == $past(core_out) && s.pin_oe == $past(core_oe))
      else $error("pins left the core under sample");

endmodule : bst_tap

`default_nettype wire

// ---- tb/bst_tester.sv ----
// Behavioural boundary-scan tester that drives the scan link of the port.
`timescale 1ns/1ps
`default_nettype none

module bst_tester (
   input wire logic core_clk,
   input wire logic scan_data_out,
   output logic scan_clock,
   output logic scan_mode_select,
   output logic scan_data_in
);
   // The scan clock stands low between steps; it only runs while a step is in progress.
   initial begin
      scan_clock = 1'b0;
      scan_mode_select = 1'b1;
      scan_data_in = 1'b1;
   end

   // One scan period: four core cycles low, four high; data out is taken just before the fall.
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      @(posedge core_clk);
      #1 scan_mode_select = tms;
      scan_data_in = tdi;
      repeat (3) @(posedge core_clk);
      #1 scan_clock = 1'b1;
      repeat (4) @(posedge core_clk);
      #1 tdo = scan_data_out;
      scan_clock = 1'b0;
      // Data in is no longer held, so it flips to avoid a stale level passing for a good one.
      scan_data_in = ~tdi;
   endtask : step

   // A full scan from Run-Test-Idle back to Run-Test-Idle, shifting n bits LSB first.
   task automatic scan(input logic is_ir, input int n, input logic [63:0] din, output logic [63:0] dout);
      logic t;
      dout = '0;
      step(1'b1, 1'b0, t);
      if (is_ir) begin
         step(1'b1, 1'b0, t);
      end
      step(1'b0, 1'b0, t);
      step(1'b0, 1'b0, t);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], t);
         dout[i] = t;
      end
      step(1'b1, 1'b0, t);
      step(1'b0, 1'b0, t);
   endtask : scan
endmodule : bst_tester

`default_nettype wire

// ---- tb/bst_tap_tb.sv ----
// Self-checking testbench of the boundary-scan test access port.
`timescale 1ns/1ps
`default_nettype none

module bst_tap_tb;
   import bst_pkg::*;
   // ------------------------------------------------------------
   // Signals and identity fields
   // ------------------------------------------------------------
   localparam logic [3:0] VER = 4'h6; // Arbitrary value.
   localparam logic [15:0] PART = 16'h3e21; // Arbitrary value.
   localparam logic [10:0] MFR = 11'h2b7; // Arbitrary value.
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic scan_clock, scan_mode_select, scan_data_in, scan_data_out, scan_data_out_oe;
   logic [7:0] pin_in = 8'h00;
   logic [7:0] core_out = 8'h00;
   logic core_oe = 1'b0;
   logic [7:0] pin_out;
   logic pin_oe;
   logic [2:0] cur_instr;
   logic [15:0] tap_state;
   logic [63:0] d;
   int error_cnt = 0;
   int check_count = 0;

   // Core clock at 50 MHz.
   always #10 core_clk = ~core_clk;

   bst_tap #(.N_IN(8), .N_OUT(8), .ID_VERSION(VER), .ID_PART(PART), .ID_MFR(MFR)) dut (
      .core_clk(core_clk), .srst(srst), .scan_clock(scan_clock), .scan_mode_select(scan_mode_select),
      .scan_data_in(scan_data_in), .scan_data_out(scan_data_out), .scan_data_out_oe(scan_data_out_oe),
      .pin_in(pin_in), .core_out(core_out), .core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe),
      .cur_instr(cur_instr), .tap_state(tap_state));

   bst_tester tester (.core_clk(core_clk), .scan_data_out(scan_data_out), .scan_clock(scan_clock),
      .scan_mode_select(scan_mode_select), .scan_data_in(scan_data_in));

   // ------------------------------------------------------------
   // Shared helpers
   // ------------------------------------------------------------
   // Compares with case equality, so an unknown never passes.
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic go(input logic tms);
      logic t;
      tester.step(tms, 1'b0, t);
   endtask : go

   task automatic load_ir(input logic [2:0] code);
      tester.scan(1'b1, 3, {61'h0, code}, d);
   endtask : load_ir

   task automatic stop_test;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      chk(tap_state, ST_TLR);
      chk(cur_instr, INSTR_IDCODE);
      @(posedge core_clk);
      #1 core_out = 8'ha5;
      core_oe = 1'b1;
      repeat (3) @(posedge core_clk);
      chk({pin_oe, pin_out}, 9'h1a5);
   endtask : t_reset

   task automatic t_idle;
      go(1'b1);
      chk(tap_state, ST_TLR);
      go(1'b0);
      chk(tap_state, ST_RTI);
      go(1'b0);
      chk(tap_state, ST_RTI);
   endtask : t_idle

   // Walks every state and every branch but the Test-Logic-Reset, Run-Test-Idle and Shift-IR holds; state digits are one-hot bit indices.
   task automatic t_walk;
      string tms_s;
      string st_s;
      int b;
      tms_s = "1010010011010010111100100101111010110111";
      st_s = "23566744581234567829abcddebcf29acdef1290";
      for (int i = 0; i < 40; i++) begin
         go(tms_s[i] == "1");
         b = (st_s[i] >= "a") ? st_s[i] - 87 : st_s[i] - 48;
         chk(tap_state, 16'h1 << b);
         // The fall just made settles serial out enable three core cycles later.
         repeat (4) @(posedge core_clk);
         #1 chk(scan_data_out_oe, b == 4 || b == 11);
      end
      go(1'b0);
   endtask : t_walk

   task automatic t_ircap;
      load_ir(INSTR_BYPASS);
      chk(d[1:0], 2'h1);
      chk(d[2:0], IR_CAPTURE);
      chk(cur_instr, INSTR_BYPASS);
   endtask : t_ircap

   // Returning through Test-Logic-Reset puts the identification register back in the path.
   task automatic t_idcode;
      repeat (5) go(1'b1);
      chk(cur_instr, INSTR_IDCODE);
      go(1'b0);
      tester.scan(1'b0, 32, 64'h0, d);
      chk(d[31:0], {VER, PART, MFR, 1'b1});
   endtask : t_idcode

   // The one-stage path delays data in by one bit behind the captured zero.
   task automatic t_bypass;
      logic [2:0] codes [3];
      codes = '{INSTR_HIGHZ, INSTR_BYPASS, 3'h5};
      foreach (codes[i]) begin
         load_ir(codes[i]);
         tester.scan(1'b0, 4, 64'hb, d);
         chk(d[3:0], {3'h3, BYPASS_CAPTURE});
         chk(pin_oe, codes[i] != INSTR_HIGHZ);
      end
      chk(pin_out, 8'ha5);
   endtask : t_bypass

   task automatic t_sample;
      pin_in = 8'h5a;
      core_out = 8'hc3;
      load_ir(INSTR_SAMPLE);
      tester.scan(1'b0, 17, {47'h0, 1'b1, 8'h96, 8'h00}, d);
      chk(d[16:0], {1'b1, 8'hc3, 8'h5a});
      chk(pin_out, 8'hc3);
   endtask : t_sample

   // Preloaded latches reach the pins once the instruction is current.
   task automatic t_extest;
      pin_in = 8'h33;
      load_ir(INSTR_EXTEST);
      chk({pin_oe, pin_out}, 9'h196);
      tester.scan(1'b0, 17, {47'h0, 1'b0, 8'h3c, 8'h00}, d);
      chk(d[7:0], 8'h33);
      chk({pin_oe, pin_out}, 9'h03c);
   endtask : t_extest

   task automatic t_clamp;
      load_ir(INSTR_CLAMP);
      core_out = 8'h0f;
      repeat (4) @(posedge core_clk);
      chk({pin_oe, pin_out}, 9'h03c);
   endtask : t_clamp

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (12) @(posedge core_clk);
      #1 srst = 1'b0;
      t_reset();
      t_idle();
      t_walk();
      t_ircap();
      t_idcode();
      t_bypass();
      t_sample();
      t_extest();
      t_clamp();
      stop_test();
   end

   // The run needs about 40 us; a hang is cut off well after that.
   initial begin
      #500000;
      error_cnt++;
      stop_test();
   end
endmodule : bst_tap_tb

`default_nettype wire
